// *** src/srs_top.sv ***
// startup reset sequencer: power-on reset, reset combine, clock request and sleep timing
`timescale 1ns/100ps
`default_nettype none
module srs_top #(
   parameter int unsigned POR_CYC   = srs_pkg::POR_CYC,
   parameter int unsigned CLKREQ_CYC = srs_pkg::CLKREQ_CYC,
   parameter int unsigned SLEEP_CYC = srs_pkg::SLEEP_CYC,
   parameter int unsigned SLOW_WIN  = srs_pkg::SLOW_WIN_CYC
) (
   input  wire logic          clk_sys,
   input  wire logic          resetn,
   input  wire logic          ext_resetn,
   input  wire logic          core_supply_ok,
   input  wire logic          slow_clock_input,
   input  wire logic          ref_oscillator_present,
   output logic               global_resetn,
   output logic               clk_req,
   output logic               sleep_done,
   output srs_pkg::srs_status_t status
);
   localparam int CW = srs_pkg::CNT_W;

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic ext_rstn_s;
   logic supply_s;
   logic slow_s;
   logic ref_s;

   srs_sync #(.RST_VAL(1'b0)) u_sync_ext (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .din     (ext_resetn),
      .dout    (ext_rstn_s)
   );
   srs_sync #(.RST_VAL(1'b0)) u_sync_sup (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .din     (core_supply_ok),
      .dout    (supply_s)
   );
   srs_sync #(.RST_VAL(1'b0)) u_sync_slow (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .din     (slow_clock_input),
      .dout    (slow_s)
   );
   srs_sync #(.RST_VAL(1'b0)) u_sync_ref (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .din     (ref_oscillator_present),
      .dout    (ref_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // power-on reset timer: counts from the supply crossing its threshold
   logic [CW-1:0] por_cnt_q, por_cnt_d;
   logic          por_done_q, por_done_d;

   always_comb begin
      por_cnt_d  = por_cnt_q;
      por_done_d = por_done_q;
      if (!supply_s) begin
         // supply dip restarts the power-on reset
         por_cnt_d  = '0;
         por_done_d = 1'b0;
      end else if (!por_done_q) begin
         if (por_cnt_q == CW'(POR_CYC - 1)) begin
            por_done_d = 1'b1; // R4
         end else begin
            por_cnt_d = por_cnt_q + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         por_cnt_q  <= '0;
         por_done_q <= 1'b0;
      end else begin
         por_cnt_q  <= por_cnt_d;
         por_done_q <= por_done_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset combine; both sources already on clk_sys so release is one edge
   logic rel_q, rel_d;

   always_comb begin
      // either source low holds reset; last to release wins
      rel_d = ext_rstn_s & por_done_q; // R1 R2 R3 R10
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rel_q <= 1'b0;
      end else begin
         rel_q <= rel_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   srs_pkg::srs_state_t st_q, st_d;
   logic [CW-1:0] seq_cnt_q, seq_cnt_d;
   logic          req_q, req_d;
   logic          done_q, done_d;

   always_comb begin
      st_d      = st_q;
      seq_cnt_d = seq_cnt_q;
      req_d     = req_q;
      done_d    = done_q;
      if (!rel_q) begin
         st_d      = srs_pkg::SRS_RESET; // R1
         seq_cnt_d = '0;
         req_d     = 1'b0;
         done_d    = 1'b0;
      end else begin
         unique case (st_q)
            srs_pkg::SRS_RESET: begin
               st_d      = srs_pkg::SRS_SLEEP;
               seq_cnt_d = '0;
            end
            srs_pkg::SRS_SLEEP: begin
               seq_cnt_d = seq_cnt_q + CW'(1);
               if (seq_cnt_q == CW'(CLKREQ_CYC - 1)) begin
                  req_d = 1'b1; // R5
               end
               if (seq_cnt_q == CW'(SLEEP_CYC - 1)) begin
                  st_d   = srs_pkg::SRS_RUN; // R6 R7
                  done_d = 1'b1;
               end
            end
            srs_pkg::SRS_RUN: begin
               seq_cnt_d = seq_cnt_q;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_q      <= srs_pkg::SRS_RESET;
         seq_cnt_q <= '0;
         req_q     <= 1'b0;
         done_q    <= 1'b0;
      end else begin
         st_q      <= st_d;
         seq_cnt_q <= seq_cnt_d;
         req_q     <= req_d;
         done_q    <= done_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock source choice, made during sleep and frozen at its end
   logic          slow_prev_q, slow_prev_d;
   logic [CW-1:0] win_cnt_q, win_cnt_d;
   logic          int_slow_q, int_slow_d;
   logic          xtal_q, xtal_d;

   always_comb begin
      slow_prev_d = slow_s;
      win_cnt_d   = win_cnt_q;
      int_slow_d  = int_slow_q;
      xtal_d      = xtal_q;
      if (st_q == srs_pkg::SRS_SLEEP) begin
         // cycles since the last slow-clock edge, saturating at the window
         if (slow_s != slow_prev_q) begin
            win_cnt_d = '0;
         end else if (win_cnt_q != CW'(SLOW_WIN)) begin
            win_cnt_d = win_cnt_q + CW'(1);
         end
         // judged only once the oscillators must be running
         if (seq_cnt_q == CW'(SLEEP_CYC - 1)) begin
            int_slow_d = (win_cnt_d == CW'(SLOW_WIN)); // R8
            xtal_d     = !ref_s; // R9
         end
      end else begin
         // a clock that stopped before sleep must not count as present
         win_cnt_d = CW'(SLOW_WIN);
         if (!rel_q) begin
            int_slow_d = 1'b0;
            xtal_d     = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         slow_prev_q <= 1'b0;
         win_cnt_q   <= '0;
         int_slow_q  <= 1'b0;
         xtal_q      <= 1'b0;
      end else begin
         slow_prev_q <= slow_prev_d;
         win_cnt_q   <= win_cnt_d;
         int_slow_q  <= int_slow_d;
         xtal_q      <= xtal_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         global_resetn <= 1'b0;
         clk_req       <= 1'b0;
         sleep_done    <= 1'b0;
         status        <= '0;
      end else begin
         global_resetn <= rel_d;
         clk_req       <= req_d;
         sleep_done    <= done_d;
         status        <= '{use_int_slow: int_slow_d, use_crystal: xtal_d,
                            run: (st_d == srs_pkg::SRS_RUN)};
      end
   end
endmodule
`default_nettype wire

// *** src/srs_pkg.sv ***
// constants and types shared by the startup reset sequencer
// What this block does
// [R1] global reset stays asserted while the external reset input or the power-on reset is asserted.
// [R2] the chip leaves reset when the later of the two reset sources releases.
// [R3] startup works both from a held external reset and from power-up alone.
// [R4] power-on reset holds typically 3 ms after the core supply passes 0.8V, never under 1.5 ms.
// [R5] about 120 us after leaving reset the reference-clock request output rises.
// [R6] after leaving reset the chip stays asleep at least 4.2 ms before going on.
// [R7] the reference oscillator and slow clock, where fitted, oscillate by the end of the sleep time.
// [R8] with no external slow clock seen on its input, the internal slow sleep clock is used.
// [R9] with no reference oscillator fitted, the crystal pins are taken as driving a crystal.
// [R10] release of the combined reset is synchronised so all counters leave reset on one edge.
package srs_pkg;
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned POR_TYP_US    = 3000;
   localparam int unsigned POR_MIN_US    = 1500;
   localparam int unsigned CLKREQ_US     = 120;
   localparam int unsigned SLEEP_MIN_US  = 4200;
   // least times scale to whole cycles; cycles per microsecond round down
   localparam int unsigned POR_CYC       = (POR_TYP_US * (CLK_HZ / 1_000_000));
   localparam int unsigned POR_MIN_CYC   = (POR_MIN_US * (CLK_HZ / 1_000_000));
   localparam int unsigned CLKREQ_CYC    = (CLKREQ_US * (CLK_HZ / 1_000_000));
   localparam int unsigned SLEEP_CYC     = (SLEEP_MIN_US * (CLK_HZ / 1_000_000));
   // slow clock seen as present if it toggles within this many cycles
   localparam int unsigned SLOW_WIN_CYC  = 1000;
   localparam int unsigned CNT_W         = 16;

   typedef enum logic [1:0] {
      SRS_RESET,
      SRS_SLEEP,
      SRS_RUN
   } srs_state_t;

   typedef struct packed {
      logic use_int_slow;
      logic use_crystal;
      logic run;
   } srs_status_t;
endpackage

// *** src/srs_sync.sv ***
// two-flop synchroniser with asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module srs_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic din,
   output logic      dout
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule
`default_nettype wire

// *** bench/srs_chk_properties.sv ***
// assertion checker for the startup reset sequencer
`timescale 1ns/100ps
`default_nettype none
module srs_chk #(
   parameter int unsigned POR_CYC    = 30,
   parameter int unsigned CLKREQ_CYC = 12,
   parameter int unsigned SLEEP_CYC  = 60
) (
   input wire logic                 clk_sys,
   input wire logic                 resetn,
   input wire logic                 ext_resetn,
   input wire logic                 core_supply_ok,
   input wire logic                 slow_clock_input,
   input wire logic                 ref_oscillator_present,
   input wire logic                 global_resetn,
   input wire logic                 clk_req,
   input wire logic                 sleep_done,
   input wire srs_pkg::srs_status_t status
);
   int unsigned sup_q, sup_d, up_q, up_d;
   logic        seen_q, seen_d, slow_q;
   always_comb begin
      sup_d = core_supply_ok ? sup_q + 1 : 0;
      up_d = global_resetn ? up_q + 1 : 0;
      seen_d = global_resetn & (seen_q | (!sleep_done & (slow_clock_input != slow_q)));
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sup_q <= 0;
         up_q <= 0;
         seen_q <= 1'b0;
         slow_q <= 1'b0;
      end else begin
         sup_q <= sup_d;
         up_q <= up_d;
         seen_q <= seen_d;
         slow_q <= slow_clock_input;
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_ext_hold: assert property (global_resetn |-> $past(ext_resetn, 3))
      else $error("chip released while external reset low");
   a_supply_hold: assert property (global_resetn |-> $past(core_supply_ok, 4))
      else $error("chip released while supply low");
   a_later_source: assert property ($rose(global_resetn) |-> $past(ext_resetn, 2))
      else $error("release before external reset released");
   a_por_length: assert property ($rose(global_resetn) |-> sup_q >= POR_CYC)
      else $error("power-on reset too short");
   a_release_sync: assert property ($rose(global_resetn) |->
      !clk_req && !sleep_done && status == 3'h0)
      else $error("outputs not leaving reset together");
   a_clkreq_time: assert property ($rose(clk_req) |->
      up_q inside {[CLKREQ_CYC:CLKREQ_CYC + 2]})
      else $error("clock request at wrong time");
   a_sleep_min: assert property (sleep_done |-> up_q >= SLEEP_CYC && clk_req && status.run)
      else $error("sleep ended early");
   a_int_slow: assert property ($rose(sleep_done) |-> status.use_int_slow == !seen_q)
      else $error("slow clock choice wrong");
   a_crystal_choice: assert property ($rose(sleep_done) |->
      status.use_crystal == !ref_oscillator_present)
      else $error("crystal choice wrong");
endmodule
bind srs_top srs_chk #(.POR_CYC(POR_CYC), .CLKREQ_CYC(CLKREQ_CYC), .SLEEP_CYC(SLEEP_CYC)) u_chk (
   .clk_sys(clk_sys), .resetn(resetn), .ext_resetn(ext_resetn), .core_supply_ok(core_supply_ok),
   .slow_clock_input(slow_clock_input), .ref_oscillator_present(ref_oscillator_present),
   .global_resetn(global_resetn), .clk_req(clk_req), .sleep_done(sleep_done), .status(status));
`default_nettype wire

// *** bench/srs_far_end.sv ***
// far-side model: reference oscillator and external slow clock
`timescale 1ns/100ps
`default_nettype none
module srs_far_end (
   input  wire logic clk_sys,
   input  wire logic osc_fit,
   input  wire logic slow_fit,
   output var logic  slow_clock_input = 1'b0,
   output var logic  ref_oscillator_present = 1'b0
);
   logic [1:0] div_q = 2'h0;
   // clocks run from power-up, well ahead of the end of sleep
   always @(posedge clk_sys) begin
      div_q <= div_q + 2'h1;
      slow_clock_input <= slow_fit & div_q[1];
      ref_oscillator_present <= osc_fit;
   end
endmodule
`default_nettype wire

// *** bench/srs_top_tb.sv ***
// self-checking bench for the startup reset sequencer
`timescale 1ns/100ps
`default_nettype none
module srs_top_tb;
   localparam int POR = 30;
   localparam int REQ = 12;
   localparam int SLP = 60;
   logic clk_sys, resetn, ext_resetn, core_supply_ok, osc_fit, slow_fit, slow_in, osc_in;
   logic global_resetn, clk_req, sleep_done;
   srs_pkg::srs_status_t status;
   int bad_count, checks, cyc;
   srs_top #(.POR_CYC(POR), .CLKREQ_CYC(REQ), .SLEEP_CYC(SLP), .SLOW_WIN(1000)) DUT (
      .clk_sys(clk_sys), .resetn(resetn), .ext_resetn(ext_resetn),
      .core_supply_ok(core_supply_ok), .slow_clock_input(slow_in),
      .ref_oscillator_present(osc_in), .global_resetn(global_resetn), .clk_req(clk_req),
      .sleep_done(sleep_done), .status(status));
   srs_far_end FAR (.clk_sys(clk_sys), .osc_fit(osc_fit), .slow_fit(slow_fit),
      .slow_clock_input(slow_in), .ref_oscillator_present(osc_in));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // counts cycles until the chosen output is high, bounded
   task automatic wait_hi(input int sel, output int n);
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (n < 500 && !(sel == 0 ? global_resetn === 1'b1 :
         sel == 1 ? clk_req === 1'b1 : sleep_done === 1'b1));
   endtask
   task automatic run_case(input logic osc, input logic slow, input int hold);
      int n, lo;
      @(posedge clk_sys);
      core_supply_ok <= 1'b0;
      ext_resetn <= 1'b0;
      osc_fit <= osc;
      slow_fit <= slow;
      repeat (5) @(posedge clk_sys);
      #1;
      check("outputs_in_reset", {global_resetn, clk_req, sleep_done, status}, 6'h0);
      @(posedge clk_sys);
      core_supply_ok <= 1'b1;
      repeat (hold) @(posedge clk_sys);
      ext_resetn <= 1'b1;
      #1;
      if (hold > POR + 5) check("held_by_ext", global_resetn, 1'b0);
      wait_hi(0, n);
      lo = (hold > POR) ? hold + 2 : POR + 2;
      check("release_time", (n + hold >= lo) && (n + hold <= lo + 3), 1'b1);
      wait_hi(1, n);
      check("clk_req_delay", n, REQ + 1);
      wait_hi(2, n);
      check("sleep_delay", n, SLP - REQ);
      check("status", status, {!slow, !osc, 1'b1});
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   initial begin
      int holds[$];
      resetn = 1'b0;
      ext_resetn = 1'b0;
      core_supply_ok = 1'b0;
      osc_fit = 1'b0;
      slow_fit = 1'b0;
      void'($urandom(47572));
      holds = '{0, 80};
      repeat (4) holds.push_back($urandom_range(80));
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      foreach (holds[i]) begin
         run_case(i < 4 ? i[0] : $urandom_range(1), i < 4 ? i[1] : $urandom_range(1), holds[i]);
         $display("case %0d done, hold %0d", i, holds[i]);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
